//--- common/hw_mult_params.svh
// Register indices, field positions and reset values of the multiplier.
`ifndef HW_MULT_PARAMS_SVH
`define HW_MULT_PARAMS_SVH

// ****************************************************************
// Register indices; the byte address is four times the index.
// ****************************************************************
`define IDX_OP1_UNSIGNED_MUL 12'h130
`define IDX_OP1_SIGNED_MUL   12'h132
`define IDX_OP1_UNSIGNED_ACC 12'h134
`define IDX_OP1_SIGNED_ACC   12'h136
`define IDX_SECOND_OPERAND   12'h138
`define IDX_RESULT_LOW_WORD  12'h13a
`define IDX_RESULT_HIGH_WORD 12'h13c
`define IDX_SUM_EXTENSION    12'h13e

// ****************************************************************
// Field positions and encodings.
// ****************************************************************
`define OP1_MODE_LSB   3
`define STRB_LOW_BYTE  2'h1
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2

// ****************************************************************
// Reset values.
// ****************************************************************
`define OPERAND_RESET  16'h0000
`define RESULT_RESET   16'h0000
`define SUM_EXTENSION_RESET   16'h0000

`endif

//--- common/hw_mult_pkg.sv
// Types shared by the multiplier modules.
package hw_mult_pkg;

	typedef enum logic [1:0] {
		MODE_UNSIGNED_MUL = 2'b00,
		MODE_SIGNED_MUL   = 2'b01,
		MODE_UNSIGNED_ACC = 2'b10,
		MODE_SIGNED_ACC   = 2'b11
	} mult_mode_t;

	typedef enum logic [2:0] {
		SEL_NONE   = 3'b000,
		SEL_OP1    = 3'b001,
		SEL_OP2    = 3'b010,
		SEL_RESLOW = 3'b011,
		SEL_RESHIGH = 3'b100,
		SEL_EXT    = 3'b101
	} reg_sel_t;

endpackage

//--- verilog/operand_extend.sv
// Byte merge and width extension of one operand write.
`timescale 1ns/1ns
`include "hw_mult_params.svh"

module operand_extend #(
	parameter int W = 16,
	parameter int N = 8
) (
	input  wire logic [W-1:0] old_value,
	input  wire logic [W-1:0] wr_data,
	input  wire logic [1:0]   wr_strb,
	input  wire logic         sign_ext,
	output logic      [W-1:0] value
);

	logic [W-1:0] merged;

	// A write of the low byte lane alone loads an N-bit operand.
	always_comb begin
		merged = old_value;
		if (wr_strb[0]) begin
			merged[N-1:0] = wr_data[N-1:0];
		end
		if (wr_strb[1]) begin
			merged[W-1:N] = wr_data[W-1:N];
		end
		if (wr_strb == `STRB_LOW_BYTE) begin
			value = {{(W-N){sign_ext & merged[N-1]}}, merged[N-1:0]}; // RULE_01
		end else begin
			value = merged;
		end
	end

endmodule

//--- verilog/product_sum.sv
// Single-cycle multiply with optional accumulate and sum extension.
`timescale 1ns/1ns

module product_sum #(
	parameter int W = 16
) (
	input  wire logic [W-1:0]   op_a,
	input  wire logic [W-1:0]   op_b,
	input  wire logic           is_signed,
	input  wire logic           accumulate,
	input  wire logic [2*W-1:0] acc_in,
	output logic      [2*W-1:0] result,
	output logic      [W-1:0]   ext
);

	logic signed [2*W+1:0] prod_full;
	logic        [2*W-1:0] prod;
	logic        [2*W:0]   sum;

	// Operands widen by one bit so one signed multiplier serves both modes.
	assign prod_full = $signed({is_signed & op_a[W-1], op_a})
		* $signed({is_signed & op_b[W-1], op_b}); // RULE_02
	assign prod = prod_full[2*W-1:0];
	assign sum = {1'b0, acc_in} + {1'b0, prod}; // RULE_03

	always_comb begin
		result = accumulate ? sum[2*W-1:0] : prod;
		case ({accumulate, is_signed})
		2'b11: begin
			ext = {W{sum[2*W-1]}};
		end
		2'b10: begin
			ext = {{(W-1){1'b0}}, sum[2*W]};
		end
		2'b01: begin
			ext = {W{prod[2*W-1]}};
		end
		default: begin
			ext = '0;
		end
		endcase
	end

endmodule

//--- verilog/hw_multiplier.sv
// Memory-mapped multiply and multiply-accumulate unit on AXI4-Lite.
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/1ns
`include "hw_mult_params.svh"

// Contract
// RULE_01 - Operands are 16 or 8 bits wide in all four pairings.
// RULE_02 - Plain multiply is available both signed and unsigned.
// RULE_03 - Multiply-accumulate adds each product to the held result, signed or unsigned.
// RULE_04 - The result is readable as soon as both operands are loaded.
// RULE_05 - No extra cycles are spent, so a read right after loading sees the result.
// RULE_06 - The first-operand register written picks the operation, latched with the operand.
// RULE_07 - The host reaches the registers over its bus with any access it likes; writes to the sum extension get OKAY but are ignored.
// RULE_08 - Writing the second operand starts the operation and updates result and extension.
module hw_multiplier #(
	parameter int ADDR_W = 16
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [ADDR_W-1:0] awaddr,
	input  wire logic [2:0]        awprot,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output logic                   wready,
	output logic      [1:0]        bresp,
	output logic                   bvalid,
	input  wire logic              bready,
	input  wire logic [ADDR_W-1:0] araddr,
	input  wire logic [2:0]        arprot,
	input  wire logic              arvalid,
	output logic                   arready,
	output logic      [31:0]       rdata,
	output logic      [1:0]        rresp,
	output logic                   rvalid,
	input  wire logic              rready
);

	// ****************************************************************
	// Declarations.
	// ****************************************************************
	logic                     aw_held_reg;
	logic [ADDR_W-1:0]        aw_addr_reg;
	logic                     w_held_reg;
	logic [15:0]              w_data_reg;
	logic [1:0]               w_strb_reg;
	logic                     bvalid_reg;
	logic [1:0]               bresp_reg;
	logic                     rvalid_reg;
	logic [31:0]              rdata_reg;
	logic [1:0]               rresp_reg;
	logic [15:0]              op1_reg;
	hw_mult_pkg::mult_mode_t  mode_reg;
	logic [15:0]              op2_reg;
	logic [15:0]              result_low_word_reg;
	logic [15:0]              result_high_word_reg;
	logic [15:0]              sum_extension_reg;
	logic                     do_write;
	hw_mult_pkg::reg_sel_t    wr_sel;
	hw_mult_pkg::reg_sel_t    rd_sel;
	hw_mult_pkg::mult_mode_t  new_mode;
	logic                     strb_any;
	logic                     wr_op1;
	logic                     wr_op2;
	logic [15:0]              op1_ext;
	logic [15:0]              op2_ext;
	logic [31:0]              core_result;
	logic [15:0]              core_ext;
	logic [15:0]              rd_value;

	// ****************************************************************
	// Address decode.
	// ****************************************************************
	function automatic hw_mult_pkg::reg_sel_t decode(input logic [ADDR_W-1:0] a);
		logic [ADDR_W-3:0] idx;
		idx = a[ADDR_W-1:2];
		case (idx)
		(ADDR_W-2)'(`IDX_OP1_UNSIGNED_MUL),
		(ADDR_W-2)'(`IDX_OP1_SIGNED_MUL),
		(ADDR_W-2)'(`IDX_OP1_UNSIGNED_ACC),
		(ADDR_W-2)'(`IDX_OP1_SIGNED_ACC): begin
			decode = hw_mult_pkg::SEL_OP1;
		end
		(ADDR_W-2)'(`IDX_SECOND_OPERAND): begin
			decode = hw_mult_pkg::SEL_OP2;
		end
		(ADDR_W-2)'(`IDX_RESULT_LOW_WORD): begin
			decode = hw_mult_pkg::SEL_RESLOW;
		end
		(ADDR_W-2)'(`IDX_RESULT_HIGH_WORD): begin
			decode = hw_mult_pkg::SEL_RESHIGH;
		end
		(ADDR_W-2)'(`IDX_SUM_EXTENSION): begin
			decode = hw_mult_pkg::SEL_EXT;
		end
		default: begin
			decode = hw_mult_pkg::SEL_NONE;
		end
		endcase
	endfunction

	assign wr_sel = decode(aw_addr_reg);
	assign rd_sel = decode(araddr);
	assign new_mode = hw_mult_pkg::mult_mode_t'(aw_addr_reg[`OP1_MODE_LSB +: 2]); // RULE_06
	assign strb_any = |w_strb_reg;
	assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;
	assign wr_op1 = do_write && strb_any && (wr_sel == hw_mult_pkg::SEL_OP1);
	assign wr_op2 = do_write && strb_any && (wr_sel == hw_mult_pkg::SEL_OP2); // RULE_08

	// ****************************************************************
	// Write address and data channels.
	// ****************************************************************
	assign awready = !aw_held_reg && !bvalid_reg;
	assign wready = !w_held_reg && !bvalid_reg;

	// Address and data are caught in either order and applied together.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_reg <= 1'b0;
			aw_addr_reg <= '0;
		end else if (awvalid && awready) begin
			aw_held_reg <= 1'b1;
			aw_addr_reg <= awaddr;
		end else if (do_write) begin
			aw_held_reg <= 1'b0;
		end
	end

	// Only the two low byte lanes carry register bits.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held_reg <= 1'b0;
			w_data_reg <= '0;
			w_strb_reg <= '0;
		end else if (wvalid && wready) begin
			w_held_reg <= 1'b1;
			w_data_reg <= wdata[15:0];
			w_strb_reg <= wstrb[1:0];
		end else if (do_write) begin
			w_held_reg <= 1'b0;
		end
	end

	// ****************************************************************
	// Write response channel.
	// ****************************************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_reg <= 1'b0;
			bresp_reg <= `RESP_OKAY;
		end else if (do_write) begin
			bvalid_reg <= 1'b1;
			bresp_reg <= (wr_sel == hw_mult_pkg::SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
		end else if (bready) begin
			bvalid_reg <= 1'b0;
		end
	end

	assign bvalid = bvalid_reg;
	assign bresp = bresp_reg;

	// ****************************************************************
	// Operand registers.
	// ****************************************************************
	operand_extend #(
		.W(16),
		.N(8)
	) u_op1_extend (
		.old_value(op1_reg),
		.wr_data  (w_data_reg),
		.wr_strb  (w_strb_reg),
		.sign_ext (new_mode[0]),
		.value    (op1_ext)
	);

	operand_extend #(
		.W(16),
		.N(8)
	) u_op2_extend (
		.old_value(op2_reg),
		.wr_data  (w_data_reg),
		.wr_strb  (w_strb_reg),
		.sign_ext (mode_reg[0]),
		.value    (op2_ext)
	);

	// The register written for the first operand fixes the operation.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			op1_reg <= `OPERAND_RESET;
			mode_reg <= hw_mult_pkg::MODE_UNSIGNED_MUL;
		end else if (wr_op1) begin
			op1_reg <= op1_ext; // RULE_01
			mode_reg <= new_mode; // RULE_06
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			op2_reg <= `OPERAND_RESET;
		end else if (wr_op2) begin
			op2_reg <= op2_ext;
		end
	end

	// ****************************************************************
	// Arithmetic and result registers.
	// ****************************************************************
	product_sum #(
		.W(16)
	) u_product_sum (
		.op_a      (op1_reg),
		.op_b      (op2_ext),
		.is_signed (mode_reg[0]),
		.accumulate(mode_reg[1]),
		.acc_in    ({result_high_word_reg, result_low_word_reg}),
		.result    (core_result),
		.ext       (core_ext)
	);

	// Results land on the same edge as the second operand and the write response.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			result_low_word_reg <= `RESULT_RESET;
			result_high_word_reg <= `RESULT_RESET;
			sum_extension_reg <= `SUM_EXTENSION_RESET;
		end else if (wr_op2) begin
			result_low_word_reg <= core_result[15:0]; // RULE_05
			result_high_word_reg <= core_result[31:16]; // RULE_03
			sum_extension_reg <= core_ext; // RULE_08
		end else if (do_write && strb_any) begin
			if (wr_sel == hw_mult_pkg::SEL_RESLOW) begin
				result_low_word_reg <= {w_strb_reg[1] ? w_data_reg[15:8] : result_low_word_reg[15:8],
					w_strb_reg[0] ? w_data_reg[7:0] : result_low_word_reg[7:0]};
			end
			if (wr_sel == hw_mult_pkg::SEL_RESHIGH) begin
				result_high_word_reg <= {w_strb_reg[1] ? w_data_reg[15:8] : result_high_word_reg[15:8],
					w_strb_reg[0] ? w_data_reg[7:0] : result_high_word_reg[7:0]};
			end
		end
	end

	// ****************************************************************
	// Read channel.
	// ****************************************************************
	assign arready = !rvalid_reg;

	always_comb begin
		case (rd_sel)
		hw_mult_pkg::SEL_OP1: begin
			rd_value = op1_reg;
		end
		hw_mult_pkg::SEL_OP2: begin
			rd_value = op2_reg;
		end
		hw_mult_pkg::SEL_RESLOW: begin
			rd_value = result_low_word_reg;
		end
		hw_mult_pkg::SEL_RESHIGH: begin
			rd_value = result_high_word_reg;
		end
		hw_mult_pkg::SEL_EXT: begin
			rd_value = sum_extension_reg;
		end
		default: begin
			rd_value = '0;
		end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_reg <= 1'b0;
			rdata_reg <= '0;
			rresp_reg <= `RESP_OKAY;
		end else if (arvalid && arready) begin
			rvalid_reg <= 1'b1;
			rdata_reg <= {16'h0000, rd_value}; // RULE_04
			rresp_reg <= (rd_sel == hw_mult_pkg::SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
		end else if (rready) begin
			rvalid_reg <= 1'b0;
		end
	end

	assign rvalid = rvalid_reg;
	assign rdata = rdata_reg;
	assign rresp = rresp_reg;

	// ****************************************************************
	// Checks.
	// ****************************************************************
	default clocking cb @(posedge aclk);
	endclocking

	default disable iff (!aresetn);

	logic        [31:0] chk_uprod;
	logic        [32:0] chk_usum;
	logic signed [31:0] chk_sprod;

	assign chk_uprod = 32'(op1_reg) * 32'(op2_ext);
	assign chk_usum = {1'b0, result_high_word_reg, result_low_word_reg} + {1'b0, chk_uprod};
	assign chk_sprod = $signed(op1_reg) * $signed(op2_ext);

	property p_byte_operand;
		wr_op1 && (w_strb_reg == `STRB_LOW_BYTE) && !new_mode[0]
			|=> op1_reg[15:8] == 8'h00;
	endproperty
	a_byte_operand: assert property (p_byte_operand) else $error("byte operand not zero extended"); // RULE_01

	property p_signed_mul;
		wr_op2 && (mode_reg == hw_mult_pkg::MODE_SIGNED_MUL)
			|=> ({result_high_word_reg, result_low_word_reg} == $past(chk_sprod))
			&& (sum_extension_reg == {16{result_high_word_reg[15]}});
	endproperty
	a_signed_mul: assert property (p_signed_mul) else $error("signed product wrong"); // RULE_02

	property p_unsigned_acc;
		wr_op2 && (mode_reg == hw_mult_pkg::MODE_UNSIGNED_ACC)
			|=> {sum_extension_reg[0], result_high_word_reg, result_low_word_reg} == $past(chk_usum);
	endproperty
	a_unsigned_acc: assert property (p_unsigned_acc) else $error("accumulate sum wrong"); // RULE_03

	property p_read_result;
		arvalid && arready && (rd_sel == hw_mult_pkg::SEL_RESLOW)
			|=> rvalid && (rdata[15:0] == $past(result_low_word_reg)) && (rresp == `RESP_OKAY);
	endproperty
	a_read_result: assert property (p_read_result) else $error("result read wrong"); // RULE_04

	property p_no_wait;
		wr_op2 && (mode_reg == hw_mult_pkg::MODE_UNSIGNED_MUL)
			|=> bvalid && ({result_high_word_reg, result_low_word_reg} == $past(chk_uprod)) && (sum_extension_reg == 16'h0000);
	endproperty
	a_no_wait: assert property (p_no_wait) else $error("result late at response"); // RULE_05

	property p_mode_latch;
		wr_op1 |=> (mode_reg == $past(new_mode)) && $stable(result_low_word_reg) ##1 $stable(mode_reg);
	endproperty
	a_mode_latch: assert property (p_mode_latch) else $error("mode not latched"); // RULE_06

	property p_start_on_op2;
		do_write && (wr_sel != hw_mult_pkg::SEL_OP2) && (wr_sel != hw_mult_pkg::SEL_RESHIGH)
			|=> $stable(result_high_word_reg) && $stable(sum_extension_reg);
	endproperty
	a_start_on_op2: assert property (p_start_on_op2) else $error("result moved without start"); // RULE_08

	property p_bresp_hold;
		bvalid && !bready |=> bvalid && $stable(bresp);
	endproperty
	a_bresp_hold: assert property (p_bresp_hold) else $error("write response dropped");

	c_signed_acc: cover property (wr_op2 && (mode_reg == hw_mult_pkg::MODE_SIGNED_ACC));
	c_byte_op2: cover property (wr_op2 && (w_strb_reg == `STRB_LOW_BYTE));
	c_bad_read: cover property (arvalid && arready && (rd_sel == hw_mult_pkg::SEL_NONE));

endmodule

//--- bench/cpu_bus_master.sv
// Bus master standing in for the processor core.
`timescale 1ns/1ns

module cpu_bus_master (
	input  wire logic        aclk,
	output logic      [15:0] awaddr,
	output logic      [2:0]  awprot,
	output logic             awvalid,
	input  wire logic        awready,
	output logic      [31:0] wdata,
	output logic      [3:0]  wstrb,
	output logic             wvalid,
	input  wire logic        wready,
	input  wire logic [1:0]  bresp,
	input  wire logic        bvalid,
	output logic             bready,
	output logic      [15:0] araddr,
	output logic      [2:0]  arprot,
	output logic             arvalid,
	input  wire logic        arready,
	input  wire logic [31:0] rdata,
	input  wire logic [1:0]  rresp,
	input  wire logic        rvalid,
	output logic             rready
);
	int lag = 0;

	initial begin
		{awaddr, araddr, wdata} = 64'h0;
		{awprot, arprot, wstrb} = 10'h0;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h0;
	end

	// Released payload is inverted so that nothing relies on stale values.
	task automatic write(input logic [15:0] a, input logic [31:0] d,
			input logic [3:0] s, output logic [1:0] resp);
		logic aw = 1'b1;
		logic w = 1'b1;
		logic ta, tw;
		logic b = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (aw || w) begin
			@(negedge aclk);
			ta = aw && awready;
			tw = w && wready;
			@(posedge aclk);
			if (ta) begin
				awvalid <= 1'b0;
				awaddr <= ~a;
			end
			if (tw) begin
				wvalid <= 1'b0;
				wdata <= ~d;
			end
			aw = aw && !ta;
			w = w && !tw;
		end
		repeat (lag) @(posedge aclk);
		bready <= 1'b1;
		while (!b) begin
			@(negedge aclk);
			b = bvalid;
			resp = bresp;
			@(posedge aclk);
		end
		bready <= 1'b0;
	endtask

	task automatic read(input logic [15:0] a, output logic [31:0] d,
			output logic [1:0] resp);
		logic t = 1'b0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		while (!t) begin
			@(negedge aclk);
			t = arready;
			@(posedge aclk);
		end
		arvalid <= 1'b0;
		araddr <= ~a;
		repeat (lag) @(posedge aclk);
		rready <= 1'b1;
		t = 1'b0;
		while (!t) begin
			@(negedge aclk);
			t = rvalid;
			d = rdata;
			resp = rresp;
			@(posedge aclk);
		end
		rready <= 1'b0;
	endtask
endmodule

//--- bench/test_hardware_multiply_accumulate.sv
// Self-checking bench of the multiply-accumulate unit.
`timescale 1ns/1ns
`include "hw_mult_params.svh"

module test_hardware_multiply_accumulate;
	logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	logic [15:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb;
	logic [2:0]  awprot, arprot;
	logic [1:0]  bresp, rresp;
	int          num_errors = 0;
	int          num_checks = 0;
	int          cycles = 0;
	logic [31:0] seed = 32'h00007319;
	logic [31:0] acc = 32'h0;
	logic [15:0] ext_m = 16'h0;

	hw_multiplier #(.ADDR_W(16)) hw_multiplier_i (.aclk, .aresetn, .awaddr, .awprot,
		.awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
		.araddr, .arprot, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);

	cpu_bus_master cpu_bus_master_i (.aclk, .awaddr, .awprot, .awvalid, .awready,
		.wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot,
		.arvalid, .arready, .rdata, .rresp, .rvalid, .rready);

	initial begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	function automatic logic [15:0] ext8(input logic [15:0] v, input logic sg);
		return {(sg && v[7]) ? 8'hff : 8'h00, v[7:0]};
	endfunction

	task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", n, exp, seen);
		end
	endtask

	task automatic report_and_stop();
		if (num_errors == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic wr(input logic [11:0] i, input logic [31:0] d, input logic [3:0] s,
			input logic [1:0] er);
		logic [1:0] r;
		cpu_bus_master_i.write({2'b00, i, 2'b00}, d, s, r);
		check("bresp", {30'h0, r}, {30'h0, er});
	endtask

	task automatic rd(input logic [11:0] i, input logic [31:0] e, input logic [1:0] er,
			input string n);
		logic [31:0] d;
		logic [1:0] r;
		cpu_bus_master_i.read({2'b00, i, 2'b00}, d, r);
		check(n, d, e);
		check("rresp", {30'h0, r}, {30'h0, er});
	endtask

	task automatic preload(input logic [31:0] v);
		wr(`IDX_RESULT_LOW_WORD, {16'h0, v[15:0]}, 4'h3, `RESP_OKAY);
		wr(`IDX_RESULT_HIGH_WORD, {16'h0, v[31:16]}, 4'h3, `RESP_OKAY);
		acc = v;
	endtask

	task automatic run_op(input logic [1:0] m, input logic [15:0] a, input logic [15:0] b,
			input logic na, input logic nb);
		logic [31:0] g, p;
		logic [32:0] s;
		logic [15:0] ea, eb;
		g = rnd();
		ea = na ? ext8(a, m[0]) : a;
		eb = nb ? ext8(b, m[0]) : b;
		if (m[0])
			p = $signed({{16{ea[15]}}, ea}) * $signed({{16{eb[15]}}, eb});
		else
			p = {16'h0, ea} * {16'h0, eb};
		s = m[1] ? {1'b0, acc} + {1'b0, p} : {1'b0, p};
		if (m[1])
			ext_m = m[0] ? {16{s[31]}} : {15'h0, s[32]};
		else
			ext_m = m[0] ? {16{p[31]}} : 16'h0;
		acc = s[31:0];
		wr(`IDX_OP1_UNSIGNED_MUL + {9'h0, m, 1'b0}, {g[31:16], a}, na ? 4'h1 : 4'h3,
			`RESP_OKAY);
		wr(`IDX_SECOND_OPERAND, {g[15:0], b}, nb ? 4'h1 : 4'h3, `RESP_OKAY);
		rd(`IDX_RESULT_LOW_WORD, {16'h0, acc[15:0]}, `RESP_OKAY, "result low");
		rd(`IDX_RESULT_HIGH_WORD, {16'h0, acc[31:16]}, `RESP_OKAY, "result high");
		rd(`IDX_SUM_EXTENSION, {16'h0, ext_m}, `RESP_OKAY, "sum extension");
	endtask

	always @(posedge aclk) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			report_and_stop();
		end
	end

	initial begin
		logic [31:0] g, h;
		aresetn = 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		for (int i = 0; i < 8; i++)
			rd(`IDX_OP1_UNSIGNED_MUL + 12'(2 * i), 32'h0, `RESP_OKAY, "reset value");
		wr(12'h140, 32'h00001234, 4'h3, `RESP_SLVERR);
		rd(12'h140, 32'h0, `RESP_SLVERR, "unmapped read");
		run_op(2'b01, 16'h0080, 16'h0080, 1'b1, 1'b1);
		run_op(2'b01, 16'h8000, 16'h00ff, 1'b0, 1'b1);
		run_op(2'b00, 16'h00ff, 16'hffff, 1'b1, 1'b0);
		run_op(2'b00, 16'hffff, 16'hffff, 1'b0, 1'b0);
		preload(32'hffffffff);
		run_op(2'b10, 16'h0001, 16'h0001, 1'b0, 1'b0);
		preload(32'h00000000);
		run_op(2'b11, 16'h0001, 16'hffff, 1'b0, 1'b0);
		wr(`IDX_SUM_EXTENSION, 32'h0000abcd, 4'h3, `RESP_OKAY);
		rd(`IDX_SUM_EXTENSION, {16'h0, ext_m}, `RESP_OKAY, "sum extension");
		preload(32'h12345678);
		wr(`IDX_RESULT_LOW_WORD, 32'h0000ab00, 4'h2, `RESP_OKAY);
		wr(`IDX_RESULT_HIGH_WORD, 32'h0000ffff, 4'h0, `RESP_OKAY);
		rd(`IDX_RESULT_LOW_WORD, 32'h0000ab78, `RESP_OKAY, "high byte write");
		rd(`IDX_RESULT_HIGH_WORD, 32'h00001234, `RESP_OKAY, "empty strobe write");
		acc = 32'h1234ab78;
		for (int k = 0; k < 60; k++) begin
			g = rnd();
			h = rnd();
			cpu_bus_master_i.lag = g[9:8];
			if (g[10])
				preload(rnd());
			run_op(g[1:0], g[31:16], h[15:0], g[2], g[3]);
		end
		report_and_stop();
	end
endmodule
